//--- rtl/tsr_pkg.sv
// package: constants, types and decode helpers of the tuner status readback block
`default_nettype none

package tsr_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] TSR_IDX_STATUS   = 6'h0A;
  localparam logic [5:0] TSR_IDX_CHANNEL  = 6'h0B;
  localparam logic [5:0] TSR_IDX_RDS_A    = 6'h0C;
  localparam logic [5:0] TSR_IDX_RDS_B    = 6'h0D;
  localparam logic [5:0] TSR_IDX_RDS_C    = 6'h0E;
  localparam logic [5:0] TSR_IDX_RDS_D    = 6'h0F;
  localparam logic [5:0] TSR_IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0] TSR_IDX_IRQ_MASK = 6'h11;
  localparam logic [5:0] TSR_IDX_PINS     = 6'h12;
  localparam logic [5:0] TSR_IDX_FREQ     = 6'h13;

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int         TSR_BIT_GROUP_READY = 15;
  localparam int         TSR_BIT_STEREO      = 8;
  localparam int         TSR_BIT_SELECT      = 16;
  localparam int         TSR_IRQ_GROUP       = 0;
  localparam int         TSR_IRQ_TUNE_DONE   = 1;
  localparam logic [7:0] TSR_SIGNAL_STRENGTH_LEVEL_MAX        = 8'h4B;
  localparam logic [1:0] TSR_PIN3_STEREO     = 2'h1;
  localparam logic [1:0] TSR_BAND_EUROPE     = 2'h0;
  localparam logic [15:0] TSR_BASE_HIGH      = 16'h222E;
  localparam logic [15:0] TSR_BASE_LOW       = 16'h1DB0;
  localparam logic [4:0] TSR_SPACE_WIDE      = 5'h14;
  localparam logic [4:0] TSR_SPACE_MID       = 5'h0A;
  localparam logic [4:0] TSR_SPACE_NARROW    = 5'h05;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] TSR_WORD_RESET = 16'h0000;
  localparam logic [9:0]  TSR_TUNE_CHANNEL_RESET = 10'h000;
  localparam logic [1:0]  TSR_IRQ_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       uncorrectable;
    logic [2:0] corrected;
  } tsr_block_err_type;

  typedef struct packed {
    logic [15:0]       word_a;
    logic [15:0]       word_b;
    logic [15:0]       word_c;
    logic [15:0]       word_d;
    tsr_block_err_type err_b;
    tsr_block_err_type err_c;
    tsr_block_err_type err_d;
  } tsr_group_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] tsr_err_level(input tsr_block_err_type e);
    if (e.uncorrectable || e.corrected >= 3'h6) begin
      return 2'h3;
    end else if (e.corrected >= 3'h3) begin
      return 2'h2;
    end else if (e.corrected >= 3'h1) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : tsr_err_level

  // spacing in units of 10 kHz
  function automatic logic [4:0] tsr_spacing(input logic [1:0] sel);
    case (sel)
      2'h0:    return TSR_SPACE_WIDE;
      2'h1:    return TSR_SPACE_MID;
      default: return TSR_SPACE_NARROW;
    endcase
  endfunction : tsr_spacing

endpackage : tsr_pkg

`default_nettype wire

//--- rtl/tsr_status_readback.sv
// design: status and readback register bank of the tuner, classic wishbone slave
`default_nettype none

module tsr_status_readback
  import tsr_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  // wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output      logic [31:0]   wb_dat_o,
  output      logic          wb_ack_o,
  output      logic          irq,
  // receiver core, same clock
  input  wire logic          stereo_flag,
  input  wire logic [7:0]    raw_signal_level,
  input  wire logic [9:0]    tune_channel,
  input  wire logic          seek_active,
  input  wire logic          seek_tune_done,
  input  wire logic          group_strobe,
  input  wire tsr_group_type group_in,
  // settings held by other control registers
  input  wire logic          verbose_rds_select,
  input  wire logic [1:0]    band_select,
  input  wire logic [1:0]    spacing_select,
  input  wire logic [1:0]    pin_three_function,
  // pins
  input  wire logic          serial_select_n,
  input  wire logic          reference_clock,
  output      logic          general_pin_three_o,
  output      logic          general_pin_three_oe
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  sel_sync_q;
  logic [1:0]  sel_sync_d;
  logic [1:0]  ref_sync_q;
  logic [1:0]  ref_sync_d;
  logic        ref_last_q;
  logic        ref_last_d;
  logic [15:0] ref_count_q;
  logic [15:0] ref_count_d;
  logic        ref_rise;

  always_comb begin
    sel_sync_d  = {sel_sync_q[0], serial_select_n};
    ref_sync_d  = {ref_sync_q[0], reference_clock};
    ref_last_d  = ref_sync_q[1];
    ref_rise    = ref_sync_q[1] && !ref_last_q;
    ref_count_d = ref_rise ? ref_count_q + 16'h0001 : ref_count_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sel_sync_q  <= 2'h3;
      ref_sync_q  <= 2'h0;
      ref_last_q  <= 1'b0;
      ref_count_q <= TSR_WORD_RESET;
    end else begin
      sel_sync_q  <= sel_sync_d;
      ref_sync_q  <= ref_sync_d;
      ref_last_q  <= ref_last_d;
      ref_count_q <= ref_count_d;
    end
  end

  // ----------------------------------------------------------------
  // tuner state capture
  // ----------------------------------------------------------------
  logic [7:0]  signal_strength_level_q;
  logic [7:0]  signal_strength_level_d;
  logic        stereo_q;
  logic        stereo_d;
  logic [9:0]  tune_channel_q;
  logic [9:0]  tune_channel_d;
  logic [15:0] freq_q;
  logic [15:0] freq_d;
  logic [15:0] word_a_q;
  logic [15:0] word_a_d;
  logic [15:0] word_b_q;
  logic [15:0] word_b_d;
  logic [15:0] word_c_q;
  logic [15:0] word_c_d;
  logic [15:0] word_d_q;
  logic [15:0] word_d_d;
  logic [5:0]  blk_err_q;
  logic [5:0]  blk_err_d;
  logic [14:0] freq_step;

  always_comb begin
    stereo_d = stereo_flag;
    // clamp keeps hot signals from reading above the documented ceiling
    signal_strength_level_d   = (raw_signal_level > TSR_SIGNAL_STRENGTH_LEVEL_MAX) ? TSR_SIGNAL_STRENGTH_LEVEL_MAX : raw_signal_level;
    tune_channel_d   = (seek_active || seek_tune_done) ? tune_channel : tune_channel_q;
    freq_step = 15'(tune_channel_q) * 15'(tsr_spacing(spacing_select));
    if (band_select == TSR_BAND_EUROPE) begin
      freq_d = TSR_BASE_HIGH + {1'b0, freq_step};
    end else begin
      freq_d = TSR_BASE_LOW + {1'b0, freq_step};
    end
    word_a_d  = word_a_q;
    word_b_d  = word_b_q;
    word_c_d  = word_c_q;
    word_d_d  = word_d_q;
    blk_err_d = blk_err_q;
    // one strobe loads every word and level, so a group never mixes
    if (group_strobe) begin
      word_a_d = group_in.word_a;
      word_b_d = group_in.word_b;
      word_c_d = group_in.word_c;
      word_d_d = group_in.word_d;
      if (verbose_rds_select) begin
        blk_err_d = {tsr_err_level(group_in.err_b),
                     tsr_err_level(group_in.err_c),
                     tsr_err_level(group_in.err_d)};
      end else begin
        blk_err_d = 6'h00;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stereo_q  <= 1'b0;
      signal_strength_level_q    <= 8'h00;
      tune_channel_q    <= TSR_TUNE_CHANNEL_RESET;
      freq_q    <= TSR_WORD_RESET;
      word_a_q  <= TSR_WORD_RESET;
      word_b_q  <= TSR_WORD_RESET;
      word_c_q  <= TSR_WORD_RESET;
      word_d_q  <= TSR_WORD_RESET;
      blk_err_q <= 6'h00;
    end else begin
      stereo_q  <= stereo_d;
      signal_strength_level_q    <= signal_strength_level_d;
      tune_channel_q    <= tune_channel_d;
      freq_q    <= freq_d;
      word_a_q  <= word_a_d;
      word_b_q  <= word_b_d;
      word_c_q  <= word_c_d;
      word_d_q  <= word_d_d;
      blk_err_q <= blk_err_d;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave, flags and interrupt
  // ----------------------------------------------------------------
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic        ack_q;
  logic        ack_d;
  logic        ready_q;
  logic        ready_d;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_stat_d;
  logic [1:0]  irq_mask_q;
  logic [1:0]  irq_mask_d;
  logic        irq_q;
  logic        irq_d;
  logic        pin3_q;
  logic        pin3_d;
  logic        pin3_oe_q;
  logic        pin3_oe_d;
  logic        take;
  logic [5:0]  idx;
  logic [1:0]  irq_events;

  always_comb begin
    // a request answers one cycle after it is seen, then ack drops
    take       = wb_cyc_i && wb_stb_i && !ack_q;
    idx        = wb_adr_i[7:2];
    ack_d      = take;
    dat_d      = dat_q;
    ready_d    = ready_q;
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    irq_events = {seek_tune_done, group_strobe};
    if (take && !wb_we_i) begin
      case (idx)
        TSR_IDX_STATUS:   dat_d = {16'h0000, ready_q, 6'h00, stereo_q, signal_strength_level_q};
        TSR_IDX_CHANNEL:  dat_d = {16'h0000, blk_err_q, tune_channel_q};
        TSR_IDX_RDS_A:    dat_d = {16'h0000, word_a_q};
        TSR_IDX_RDS_B:    dat_d = {16'h0000, word_b_q};
        TSR_IDX_RDS_C:    dat_d = {16'h0000, word_c_q};
        TSR_IDX_RDS_D:    dat_d = {16'h0000, word_d_q};
        TSR_IDX_IRQ_STAT: dat_d = {30'h00000000, irq_stat_q};
        TSR_IDX_IRQ_MASK: dat_d = {30'h00000000, irq_mask_q};
        TSR_IDX_PINS:     dat_d = {15'h0000, !sel_sync_q[1], ref_count_q};
        TSR_IDX_FREQ:     dat_d = {16'h0000, freq_q};
        default:          dat_d = 32'h00000000;
      endcase
    end else if (take) begin
      dat_d = 32'h00000000;
    end
    // read clears sticky bits; a new event in the same cycle wins
    if (take && !wb_we_i && idx == TSR_IDX_STATUS) begin
      ready_d = 1'b0;
    end
    if (take && !wb_we_i && idx == TSR_IDX_IRQ_STAT) begin
      irq_stat_d = TSR_IRQ_RESET;
    end
    if (group_strobe) begin
      ready_d = 1'b1;
    end
    irq_stat_d = irq_stat_d | irq_events;
    // only the mask takes writes; every read-only index drops them
    if (take && wb_we_i && idx == TSR_IDX_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_d = wb_dat_i[1:0];
    end
    irq_d     = |(irq_stat_q & irq_mask_q);
    pin3_oe_d = (pin_three_function == TSR_PIN3_STEREO);
    pin3_d    = pin3_oe_d && stereo_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dat_q      <= 32'h00000000;
      ack_q      <= 1'b0;
      ready_q    <= 1'b0;
      irq_stat_q <= TSR_IRQ_RESET;
      irq_mask_q <= TSR_IRQ_RESET;
      irq_q      <= 1'b0;
      pin3_q     <= 1'b0;
      pin3_oe_q  <= 1'b0;
    end else begin
      dat_q      <= dat_d;
      ack_q      <= ack_d;
      ready_q    <= ready_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
      pin3_q     <= pin3_d;
      pin3_oe_q  <= pin3_oe_d;
    end
  end

  assign wb_dat_o             = dat_q;
  assign wb_ack_o             = ack_q;
  assign irq                  = irq_q;
  assign general_pin_three_o  = pin3_q;
  assign general_pin_three_oe = pin3_oe_q;

endmodule : tsr_status_readback

`default_nettype wire

//--- sim/testbench.sv
// testbench: reads, flags, interrupt, channel and pins of the readback block
`default_nettype none
module testbench
  import tsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, stereo_flag;
  logic          seek_active, seek_tune_done, group_strobe, verbose_rds_select, serial_select_n;
  logic          reference_clock, general_pin_three_o, general_pin_three_oe;
  logic [1:0]    band_select, spacing_select, pin_three_function;
  logic [3:0]    wb_sel_i;
  logic [5:0]    errs;
  logic [7:0]    wb_adr_i, raw_signal_level, sat;
  logic [9:0]    tune_channel, ch;
  logic [31:0]   wb_dat_i, wb_dat_o, exp_q[$];
  tsr_group_type group_in, g;
  int            bad_count, total_checks, cycles;
  tsr_status_readback uut (
    .clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq, .stereo_flag, .raw_signal_level, .tune_channel,
    .seek_active, .seek_tune_done, .group_strobe, .group_in, .verbose_rds_select,
    .band_select, .spacing_select, .pin_three_function, .serial_select_n,
    .reference_clock, .general_pin_three_o, .general_pin_three_oe
  );
  tsr_core_model core (
    .clk_sys, .group_in, .group_strobe, .tune_channel, .seek_active, .seek_tune_done,
    .reference_clock
  );
  initial forever #10 clk_sys = ~clk_sys;
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, e);
    end
  endtask : check
  // the request stands until ack is sampled, then drops for one cycle
  task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, we, 4'hF, idx, 2'h0, d};
    // no local limit: only the cycle ceiling ends a wait for ack
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'h1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [5:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'h0, idx, 32'h0);
  endtask : rd
  function automatic logic [1:0] lv(input logic [3:0] e);
    return (e[3] || e[2:0] > 3'h5) ? 2'h3 :
           (e[2:0] > 3'h2) ? 2'h2 : {1'b0, e[2:0] > 3'h0};
  endfunction : lv
  always @(posedge clk_sys) begin
    cycles++;
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && exp_q.size() > 0) begin
      check(wb_dat_o, exp_q.pop_front());
    end
    if (cycles > 5000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i, stereo_flag, reset_n} = '0;
    {raw_signal_level, verbose_rds_select, band_select, spacing_select, pin_three_function} = '0;
    {bad_count, total_checks, cycles, errs, ch, clk_sys} = '0;
    serial_select_n = 1'h1;
    void'($urandom(32'h03E0F81B));
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(posedge clk_sys);
    for (int i = 10; i < 19; i++) rd(6'(i), 32'h0);
    $display("reset values test done");
    for (int k = 0; k < 4; k++) begin
      stereo_flag        <= k[0];
      raw_signal_level   <= (k == 3) ? 8'($urandom) : 8'h4A + 8'(k);
      pin_three_function <= 2'(k);
      repeat (3) @(posedge clk_sys);
      sat = (raw_signal_level > 8'h4B) ? 8'h4B : raw_signal_level;
      check({30'h0, general_pin_three_oe, general_pin_three_o},
            {30'h0, k == 1, k == 1});
      rd(TSR_IDX_STATUS, {23'h0, stereo_flag, sat});
    end
    $display("level and pin test done");
    for (int k = 0; k < 9; k++) begin
      verbose_rds_select <= (k != 4);
      g = {$urandom, $urandom, 1'(k == 8), 3'(k), 4'(7 - k), 4'(k >> 1)};
      core.send_group(g);
      errs = (k != 4) ? {lv(g.err_b), lv(g.err_c), lv(g.err_d)} : 6'h0;
      for (int w = 0; w < 4; w++) rd(TSR_IDX_RDS_A + 6'(w), {16'h0, g[75 - 16 * w -: 16]});
      rd(TSR_IDX_CHANNEL, {16'h0, errs, ch});
      rd(TSR_IDX_STATUS, {16'h0, 1'h1, 6'h0, stereo_flag, sat});
      rd(TSR_IDX_STATUS, {23'h0, stereo_flag, sat});
    end
    $display("group test done");
    for (int m = 0; m < 3; m++) begin
      {band_select, spacing_select} <= {2'(m), 2'(m)};
      ch = 10'($urandom);
      core.set_tune_channel(ch, 1'h1, 1'h0);
      rd(TSR_IDX_CHANNEL, {16'h0, errs, ch});
      core.set_tune_channel(~ch, 1'h0, 1'h0);
      rd(TSR_IDX_CHANNEL, {16'h0, errs, ch});
      ch = ch + 10'h1;
      core.set_tune_channel(ch, 1'h0, 1'h1);
      rd(TSR_IDX_CHANNEL, {16'h0, errs, ch});
      rd(TSR_IDX_FREQ, (m == 0) ? 32'h222E + 32'h14 * ch
                                : 32'h1DB0 + (32'hA >> (m - 1)) * ch);
    end
    rd(TSR_IDX_IRQ_STAT, 32'h3);
    bus(1'h1, TSR_IDX_IRQ_MASK, 32'h1);
    core.send_group(g);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1);
    rd(TSR_IDX_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    bus(1'h1, TSR_IDX_RDS_A, 32'hFFFFFFFF);
    for (int i = 0; i < 2; i++) rd(TSR_IDX_RDS_A, {16'h0, g.word_a});
    rd(6'h20, 32'h0);
    $display("channel, interrupt and access test done");
    serial_select_n <= 1'h0;
    core.ref_run = 1'h1;
    repeat (300) @(posedge clk_sys);
    core.ref_run = 1'h0;
    repeat (20) @(posedge clk_sys);
    rd(TSR_IDX_PINS, {15'h0, 1'h1, 16'(core.ref_edges)});
    $display("pin test done");
    // second reset in mid-run, pin three enabled so its reset value shows
    stereo_flag        <= 1'h0;
    pin_three_function <= TSR_PIN3_STEREO;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(posedge clk_sys);
    rd(TSR_IDX_RDS_A, 32'h0);
    rd(TSR_IDX_RDS_C, 32'h0);
    rd(TSR_IDX_IRQ_MASK, 32'h0);
    rd(TSR_IDX_STATUS, {24'h0, sat});
    $display("mid-run reset test done");
    check(32'(exp_q.size()), 32'h0);
    close_out();
  end
endmodule : testbench
`default_nettype wire

//--- sim/tsr_chk.sv
// checker: bus, pin and reset relations at the block ports
`default_nettype none
module tsr_chk
  import tsr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq,
  input wire logic        stereo_flag,
  input wire logic [1:0]  pin_three_function,
  input wire logic        general_pin_three_o,
  input wire logic        general_pin_three_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic       rd;
  logic [5:0] ix;
  logic       p3;
  assign rd = wb_ack_o && !wb_we_i;
  assign ix = wb_adr_i[7:2];
  assign p3 = pin_three_function == TSR_PIN3_STEREO;
  property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_take: assert property (p_take) else $error("no ack");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_rst; $rose(reset_n) |-> !wb_ack_o && !irq && !general_pin_three_oe; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_sat; rd && ix == TSR_IDX_STATUS |-> wb_dat_o[7:0] <= TSR_SIGNAL_STRENGTH_LEVEL_MAX; endproperty
  a_sat: assert property (p_sat) else $error("level above ceiling");
  property p_hi;
    rd && ix >= TSR_IDX_STATUS && ix <= TSR_IDX_RDS_D |-> wb_dat_o[31:16] == 16'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper half set");
  property p_unmap; rd && ix > TSR_IDX_FREQ |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_pon;
    // the pin follows the registered flag, so it trails the input by two edges
    p3 |=> general_pin_three_oe && general_pin_three_o == $past(stereo_flag, 2);
  endproperty
  a_pon: assert property (p_pon) else $error("pin three not stereo");
  property p_poff; !p3 |=> !general_pin_three_oe && !general_pin_three_o; endproperty
  a_poff: assert property (p_poff) else $error("pin three driven");
  c_stat: cover property (rd && ix == TSR_IDX_STATUS && wb_dat_o[15]);
  c_irq: cover property (irq);
  c_pin: cover property (general_pin_three_oe && general_pin_three_o);
endmodule : tsr_chk
bind tsr_status_readback tsr_chk u_chk (
  .clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .irq, .stereo_flag, .pin_three_function, .general_pin_three_o, .general_pin_three_oe
);
`default_nettype wire

//--- sim/tsr_core_model.sv
// model: receiver core groups and tuning, plus the reference oscillator
`default_nettype none
module tsr_core_model
  import tsr_pkg::*;
(
  input  wire logic          clk_sys,
  output var  tsr_group_type group_in,
  output logic               group_strobe,
  output logic [9:0]         tune_channel,
  output logic               seek_active,
  output logic               seek_tune_done,
  output logic               reference_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_run;
  int   ref_edges;
  initial begin
    {group_in, group_strobe, tune_channel, seek_active, seek_tune_done} = '0;
    {reference_clock, ref_run, ref_edges} = '0;
    #7;
    // parked low when idle so the bench can count edges exactly
    forever #80 reference_clock = ref_run ? ~reference_clock : 1'h0;
  end
  always @(posedge reference_clock) ref_edges++;
  // one strobe carries all words and levels; released data is inverted
  task automatic send_group(input tsr_group_type g);
    @(posedge clk_sys);
    {group_in, group_strobe} <= {g, 1'h1};
    @(posedge clk_sys);
    {group_in, group_strobe} <= {~g, 1'h0};
  endtask : send_group
  task automatic set_tune_channel(input logic [9:0] ch, input logic act, input logic done);
    @(posedge clk_sys);
    {tune_channel, seek_active, seek_tune_done} <= {ch, act, done};
    @(posedge clk_sys);
    {tune_channel, seek_active, seek_tune_done} <= {~ch, 2'h0};
  endtask : set_tune_channel
endmodule : tsr_core_model
`default_nettype wire
